/* verilog/rsp_pkg.sv */
package rsp_pkg;

  // ---------------------------------------------------------------------------
  // Bus address and direction
  // ---------------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h68;
  localparam logic       RW_WRITE = 1'h0;
  localparam logic       RW_READ  = 1'h1;
  localparam logic       ACK      = 1'h0;
  localparam logic       NACK     = 1'h1;

  // ---------------------------------------------------------------------------
  // Byte framing
  // ---------------------------------------------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;

  // ---------------------------------------------------------------------------
  // Register space
  // ---------------------------------------------------------------------------
  localparam int         REG_DEPTH = 256;
  localparam logic [7:0] PTR_RST   = 8'h00;
  localparam logic [7:0] MEM_RST   = 8'h00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int REF_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC       = SCL_PERIOD_NS / REF_PERIOD_NS / 4;

endpackage : rsp_pkg

/* verilog/rsp_i2c_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface rsp_i2c_if;

  // ---------------------------------------------------------------------------
  // Drivers and resolved lines
  // ---------------------------------------------------------------------------
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Open-drain lines with pull-ups
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

  modport host (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input sda);
  modport dev  (output sda_s_o, output sda_s_oe, input scl, input sda);

endinterface : rsp_i2c_if

`default_nettype wire

/* verilog/rsp_sync2.sv */
`timescale 1ns/1ps
`default_nettype none

module rsp_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;

endmodule : rsp_sync2

`default_nettype wire

/* verilog/rsp_dev.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Master acks each read byte, nacks last.
// - Only master drives clock, START and STOP.
// - Repeated START begins a new address phase.
// - All bytes travel most significant bit first.
// - Device acks every byte written to it.
// - START opens a transfer, STOP closes it; device STOP only pulses stop_out, state_reg holds until the next START.
// - Address byte is 1101000 plus direction bit.
// - Matching address is acked in both directions.
// - First written byte loads pointer, acked.
// - Any number of data bytes, each acked.
// - Pointer advances after every data byte.
// - Master ends a write with STOP.
// - Read returns bytes from the current pointer.
// - Read without pointer write uses last pointer.
// - Device sends bytes until master nacks.
// - SDA edge with SCL high is START/STOP.
// - Ack held low through ninth clock high.
// - After nack, device releases data line.
module rsp_dev
  import rsp_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  // Link
  rsp_i2c_if.dev          bus,
  // User side, ref_clk_in domain
  output logic            wr_valid_out,
  output logic [7:0]      wr_addr_out,
  output logic [7:0]      wr_data_out,
  output logic            stop_out,
  output logic            busy_out
);

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA} rsp_dev_state_t;

  rsp_dev_state_t state_reg;
  logic [3:0]     bit_cnt_reg;
  logic [6:0]     shift_reg;
  logic           ack_en_reg;
  logic           rw_reg;
  logic           sda_oe_reg;
  logic [7:0]     ptr_reg;
  logic [7:0]     mem_reg [REG_DEPTH];
  logic           start_tgl_reg;
  logic           stop_tgl_reg;
  logic           start_seen_reg;
  logic           wr_tgl_reg;
  logic [7:0]     wr_addr_l_reg;
  logic [7:0]     wr_data_l_reg;
  logic           start_pend;
  logic           byte_done;
  logic [7:0]     byte_in;
  logic [7:0]     tx_byte;
  logic [2:0]     sync_q;
  logic [2:0]     sync_d_reg;

  assign start_pend = start_tgl_reg != start_seen_reg;
  assign byte_done  = !start_pend && bit_cnt_reg == BIT_LAST;
  assign byte_in    = {shift_reg, bus.sda};
  assign tx_byte    = mem_reg[ptr_reg];

  // ---------------------------------------------------------------------------
  // START and STOP detection on data edges
  // ---------------------------------------------------------------------------
  always_ff @(negedge bus.sda or posedge srst_in) begin
    if (srst_in) begin
      start_tgl_reg <= 1'b0;
    end else if (bus.scl) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  always_ff @(posedge bus.sda or posedge srst_in) begin
    if (srst_in) begin
      stop_tgl_reg <= 1'b0;
    end else if (bus.scl) begin
      stop_tgl_reg <= ~stop_tgl_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Bit and byte sequencing on rising clock
  // ---------------------------------------------------------------------------
  always_ff @(posedge bus.scl or posedge srst_in) begin
    if (srst_in) begin
      state_reg      <= S_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 7'h00;
      start_seen_reg <= 1'b0;
      ack_en_reg     <= 1'b0;
      rw_reg         <= RW_WRITE;
    end else if (start_pend) begin
      // First bit of the address byte, even mid-transfer
      start_seen_reg <= start_tgl_reg;
      state_reg      <= S_ADDR;
      bit_cnt_reg    <= 4'h1;
      shift_reg      <= {6'h00, bus.sda};
      ack_en_reg     <= 1'b0;
    end else if (bit_cnt_reg == BIT_ACK) begin
      bit_cnt_reg <= 4'h0;
      ack_en_reg  <= 1'b0;
      case (state_reg)
        S_ADDR: begin
          if (!ack_en_reg) begin
            state_reg <= S_IDLE;
          end else if (rw_reg == RW_READ) begin
            state_reg <= S_RDATA;
          end else begin
            state_reg <= S_PTR;
          end
        end
        S_PTR: begin
          state_reg <= S_WDATA;
        end
        S_RDATA: begin
          // Master nack ends the read
          if (bus.sda == NACK) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end else begin
      shift_reg   <= byte_in[6:0];
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == BIT_LAST) begin
        case (state_reg)
          S_ADDR: begin
            ack_en_reg <= byte_in[7:1] == DEV_ADDR;
            rw_reg     <= byte_in[0];
          end
          S_PTR, S_WDATA: begin
            ack_en_reg <= 1'b1;
          end
          default: begin
            ack_en_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register pointer
  // ---------------------------------------------------------------------------
  always_ff @(posedge bus.scl or posedge srst_in) begin
    if (srst_in) begin
      ptr_reg <= PTR_RST;
    end else if (byte_done) begin
      if (state_reg == S_PTR) begin
        ptr_reg <= byte_in;
      end else if (state_reg == S_WDATA || state_reg == S_RDATA) begin
        ptr_reg <= ptr_reg + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register storage and write hand-off
  // ---------------------------------------------------------------------------
  always_ff @(posedge bus.scl or posedge srst_in) begin
    if (srst_in) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem_reg[i] <= MEM_RST;
      end
      wr_tgl_reg    <= 1'b0;
      wr_addr_l_reg <= 8'h00;
      wr_data_l_reg <= 8'h00;
    end else if (byte_done && state_reg == S_WDATA) begin
      mem_reg[ptr_reg] <= byte_in;
      wr_addr_l_reg    <= ptr_reg;
      wr_data_l_reg    <= byte_in;
      wr_tgl_reg       <= ~wr_tgl_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Data line drive on falling clock
  // ---------------------------------------------------------------------------
  // Changing only on falling clock keeps SDA stable while SCL is high
  always_ff @(negedge bus.scl or posedge srst_in) begin
    if (srst_in) begin
      sda_oe_reg <= 1'b0;
    end else if (bit_cnt_reg == BIT_ACK) begin
      sda_oe_reg <= ack_en_reg;
    end else if (state_reg == S_RDATA) begin
      sda_oe_reg <= ~tx_byte[3'h7 - bit_cnt_reg[2:0]];
    end else begin
      sda_oe_reg <= 1'b0;
    end
  end

  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = sda_oe_reg;

  // ---------------------------------------------------------------------------
  // Crossing to the user side
  // ---------------------------------------------------------------------------
  rsp_sync2 #(
    .W (3)
  ) u_sync (
    .clk_in  (ref_clk_in),
    .srst_in (srst_in),
    .d_in    ({state_reg != S_IDLE, stop_tgl_reg, wr_tgl_reg}),
    .q_out   (sync_q)
  );

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sync_d_reg <= 3'h0;
    end else begin
      sync_d_reg <= sync_q;
    end
  end

  // Latched words are stable for several link bits after the toggle
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wr_valid_out <= 1'b0;
      wr_addr_out  <= 8'h00;
      wr_data_out  <= 8'h00;
      stop_out     <= 1'b0;
      busy_out     <= 1'b0;
    end else begin
      wr_valid_out <= sync_q[0] ^ sync_d_reg[0];
      stop_out     <= sync_q[1] ^ sync_d_reg[1];
      busy_out     <= sync_q[2];
      if (sync_q[0] ^ sync_d_reg[0]) begin
        wr_addr_out <= wr_addr_l_reg;
        wr_data_out <= wr_data_l_reg;
      end
    end
  end

endmodule : rsp_dev

`default_nettype wire

/* verilog/rsp_host.sv */
`timescale 1ns/1ps
`default_nettype none

module rsp_host
  import rsp_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  // Link
  rsp_i2c_if.host         bus,
  // Command
  input  wire logic       cmd_valid_in,
  output logic            cmd_ready_out,
  input  wire logic       cmd_read_in,
  input  wire logic [7:0] cmd_ptr_in,
  input  wire logic [7:0] cmd_len_in,
  // Write data
  input  wire logic       wr_valid_in,
  input  wire logic [7:0] wr_data_in,
  output logic            wr_ready_out,
  // Read data and status
  output logic            rd_valid_out,
  output logic [7:0]      rd_data_out,
  output logic            done_out,
  output logic            nack_err_out
);

  typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_WAIT, H_STOP} rsp_host_state_t;
  typedef enum logic [2:0] {P_ADDR_W, P_PTR, P_WDATA, P_ADDR_R, P_RDATA} rsp_phase_t;

  rsp_host_state_t state_reg;
  rsp_phase_t      phase_reg;
  logic [15:0]     qcnt_reg;
  logic [1:0]      q_reg;
  logic [3:0]      bit_cnt_reg;
  logic [8:0]      tx_reg;
  logic [8:0]      rx_reg;
  logic [7:0]      left_reg;
  logic [7:0]      ptr_l_reg;
  logic            read_reg;
  logic            scl_oe_reg;
  logic            sda_oe_reg;
  logic            sda_s;
  logic            tick;
  logic            run;

  assign run           = state_reg == H_START || state_reg == H_BYTE || state_reg == H_STOP;
  assign tick          = run && qcnt_reg == 16'(QTR - 1);
  assign cmd_ready_out = state_reg == H_IDLE;
  assign wr_ready_out  = state_reg == H_WAIT;

  // ---------------------------------------------------------------------------
  // Quarter-bit timer, also the clock divider
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !run) begin
      qcnt_reg <= 16'h0000;
      q_reg    <= 2'h0;
    end else if (tick) begin
      qcnt_reg <= 16'h0000;
      q_reg    <= q_reg + 2'h1;
    end else begin
      qcnt_reg <= qcnt_reg + 16'h0001;
    end
  end

  rsp_sync2 #(
    .W (1)
  ) u_sda_sync (
    .clk_in  (ref_clk_in),
    .srst_in (srst_in),
    .d_in    (bus.sda),
    .q_out   (sda_s)
  );

  // ---------------------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_reg    <= H_IDLE;
      phase_reg    <= P_ADDR_W;
      bit_cnt_reg  <= 4'h0;
      tx_reg       <= 9'h1FF;
      rx_reg       <= 9'h000;
      left_reg     <= 8'h00;
      ptr_l_reg    <= 8'h00;
      read_reg     <= 1'b0;
      scl_oe_reg   <= 1'b0;
      sda_oe_reg   <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out  <= 8'h00;
      done_out     <= 1'b0;
      nack_err_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      done_out     <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid_in) begin
            read_reg     <= cmd_read_in;
            ptr_l_reg    <= cmd_ptr_in;
            left_reg     <= cmd_len_in;
            nack_err_out <= 1'b0;
            phase_reg    <= P_ADDR_W;
            tx_reg       <= {DEV_ADDR, RW_WRITE, NACK};
            state_reg    <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            case (q_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              default: begin
                scl_oe_reg  <= 1'b1;
                bit_cnt_reg <= 4'h0;
                state_reg   <= H_BYTE;
              end
            endcase
          end
        end
        H_BYTE: begin
          if (tick) begin
            case (q_reg)
              2'h0: sda_oe_reg <= ~tx_reg[8];
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: rx_reg <= {rx_reg[7:0], sda_s};
              default: begin
                scl_oe_reg  <= 1'b1;
                tx_reg      <= {tx_reg[7:0], 1'b1};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg == BIT_ACK) begin
                  bit_cnt_reg <= 4'h0;
                  if (phase_reg == P_RDATA) begin
                    rd_data_out  <= rx_reg[8:1];
                    rd_valid_out <= 1'b1;
                    left_reg     <= left_reg - 8'h01;
                    if (left_reg == 8'h01) begin
                      state_reg <= H_STOP;
                    end else begin
                      tx_reg <= {8'hFF, (left_reg == 8'h02) ? NACK : ACK};
                    end
                  end else if (rx_reg[0] == NACK) begin
                    nack_err_out <= 1'b1;
                    state_reg    <= H_STOP;
                  end else begin
                    case (phase_reg)
                      P_ADDR_W: begin
                        phase_reg <= P_PTR;
                        tx_reg    <= {ptr_l_reg, NACK};
                      end
                      P_PTR: begin
                        if (left_reg == 8'h00) begin
                          state_reg <= H_STOP;
                        end else if (read_reg) begin
                          phase_reg <= P_ADDR_R;
                          tx_reg    <= {DEV_ADDR, RW_READ, NACK};
                          state_reg <= H_START;
                        end else begin
                          phase_reg <= P_WDATA;
                          state_reg <= H_WAIT;
                        end
                      end
                      P_WDATA: begin
                        left_reg  <= left_reg - 8'h01;
                        state_reg <= (left_reg == 8'h01) ? H_STOP : H_WAIT;
                      end
                      default: begin
                        phase_reg <= P_RDATA;
                        tx_reg    <= {8'hFF, (left_reg == 8'h01) ? NACK : ACK};
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        H_WAIT: begin
          // Clock held low until the next byte is offered
          if (wr_valid_in) begin
            tx_reg    <= {wr_data_in, NACK};
            state_reg <= H_BYTE;
          end
        end
        H_STOP: begin
          if (tick) begin
            case (q_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              default: begin
                done_out  <= 1'b1;
                state_reg <= H_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = scl_oe_reg;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = sda_oe_reg;

endmodule : rsp_host

`default_nettype wire

/* verification/rsp_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module rsp_chk (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Link drivers and resolved lines
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  // ---------------------------------------------------------------------------
  // Link properties
  // ---------------------------------------------------------------------------
  chk_open_drain: assert property (scl_o == 1'h0 && sda_m_o == 1'h0 && sda_s_o == 1'h0)
    else $error("link output value not low");
  chk_idle_release: assert property ($fell(srst_in) |-> !scl_oe && !sda_m_oe && !sda_s_oe)
    else $error("lines not released after reset");
  chk_scl_high_min: assert property ($rose(scl) |-> scl[*4])
    else $error("clock high time too short");
  chk_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("device data changed while clock high");
  chk_ack_held: assert property ($rose(scl) && sda_s_oe |-> sda_s_oe[*6])
    else $error("device low level not held through clock high");
  chk_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> $rose(sda_m_oe))
    else $error("data fell with clock high not by host");
  chk_stop_released: assert property (scl && $past(scl) && $rose(sda) |-> $fell(sda_m_oe) && !sda_s_oe)
    else $error("stop while device still drives data");
  chk_no_contention: assert property ($rose(scl) |-> !(sda_m_oe && sda_s_oe))
    else $error("both ends drive data at clock rise");

endmodule : rsp_chk

`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench
  import rsp_pkg::*;
;
  logic       ref_clk_in   = 1'h0;
  logic       srst_in      = 1'h0;
  logic       cmd_valid_in = 1'h0;
  logic       cmd_read_in  = 1'h0;
  logic [7:0] cmd_ptr_in   = 8'h00;
  logic [7:0] cmd_len_in   = 8'h00;
  logic       wr_valid_in  = 1'h0;
  logic [7:0] wr_data_in   = 8'h00;
  logic       cmd_ready_out, wr_ready_out, rd_valid_out, done_out, nack_err_out;
  logic [7:0] rd_data_out, dv_addr, dv_data;
  logic       dv_valid, dv_stop, dv_busy;
  logic [7:0] wdat [4]     = '{8'hA5, 8'h3C, 8'h81, 8'h00};
  logic [15:0] wq [$];
  logic [7:0] rdq [$];
  int         err_total    = 0;
  int         n_compared   = 0;
  int         stops        = 0;
  int         busy_hits    = 0;

  rsp_i2c_if bus1 ();
  rsp_i2c_if bus2 ();

  always #2.5 ref_clk_in = ~ref_clk_in;

  rsp_host #(.QTR(4)) rsp_host_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .bus(bus1.host),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_read_in(cmd_read_in),
    .cmd_ptr_in(cmd_ptr_in), .cmd_len_in(cmd_len_in), .wr_valid_in(wr_valid_in), .wr_data_in(wr_data_in),
    .wr_ready_out(wr_ready_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .done_out(done_out), .nack_err_out(nack_err_out));
  rsp_dev rsp_dev_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .bus(bus1.dev), .wr_valid_out(dv_valid),
    .wr_addr_out(dv_addr), .wr_data_out(dv_data), .stop_out(dv_stop), .busy_out(dv_busy));
  rsp_dev rsp_dev_inst2 (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .bus(bus2.dev), .wr_valid_out(),
    .wr_addr_out(), .wr_data_out(), .stop_out(), .busy_out());
  rsp_chk rsp_chk_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .scl_o(bus1.scl_o), .scl_oe(bus1.scl_oe),
    .sda_m_o(bus1.sda_m_o), .sda_m_oe(bus1.sda_m_oe), .sda_s_o(bus1.sda_s_o), .sda_s_oe(bus1.sda_s_oe),
    .scl(bus1.scl), .sda(bus1.sda));

  always @(posedge ref_clk_in) begin
    if (dv_valid === 1'h1) wq.push_back({dv_addr, dv_data});
    if (dv_stop === 1'h1) stops++;
    if (dv_busy === 1'h1) busy_hits++;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic complete_run;
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick;
    @(posedge ref_clk_in);
    #1;
  endtask : tick

  task automatic run_cmd(input logic rd, input logic [7:0] ptr, input logic [7:0] len);
    int n;
    int k;
    int s0;
    k = 0;
    s0 = stops;
    wq = {};
    rdq = {};
    busy_hits = 0;
    check("cmd ready", {15'h0000, cmd_ready_out}, 16'h0001);
    cmd_read_in = rd;
    cmd_ptr_in = ptr;
    cmd_len_in = len;
    cmd_valid_in = 1'h1;
    tick();
    cmd_valid_in = 1'h0;
    for (n = 0; n < 20000 && done_out !== 1'h1; n++) begin
      wr_valid_in = wr_ready_out;
      wr_data_in = wdat[k[1:0]];
      tick();
      if (wr_valid_in === 1'h1) k++;
      if (rd_valid_out === 1'h1) rdq.push_back(rd_data_out);
    end
    wr_valid_in = 1'h0;
    if (done_out !== 1'h1) begin
      err_total++;
      complete_run();
    end
    for (n = 0; n < 50 && stops == s0; n++) tick();
    check("stop count", 16'(stops - s0), 16'h0001);
    check("busy seen", {15'h0000, busy_hits != 0}, 16'h0001);
    check("nack flag", {15'h0000, nack_err_out}, 16'h0000);
  endtask : run_cmd

  // Bit on the second link, 160 ns per clock
  task automatic bb_bit(input logic b, output logic s);
    bus2.sda_m_oe = ~b;
    #40 bus2.scl_oe = 1'h0;
    #40 s = bus2.sda;
    #40 bus2.scl_oe = 1'h1;
    #40;
  endtask : bb_bit

  task automatic bb_byte(input logic [7:0] v, output logic [7:0] r, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bb_bit(v[i], s);
      r[i] = s;
    end
    bb_bit(1'h1, a);
  endtask : bb_byte

  task automatic bb_start;
    bus2.sda_m_oe = 1'h0;
    #40 bus2.scl_oe = 1'h0;
    #40 bus2.sda_m_oe = 1'h1;
    #40 bus2.scl_oe = 1'h1;
    #40;
  endtask : bb_start

  task automatic bb_stop;
    bus2.sda_m_oe = 1'h1;
    #40 bus2.scl_oe = 1'h0;
    #40 bus2.sda_m_oe = 1'h0;
    #40;
  endtask : bb_stop

  task automatic bb_ack(input logic [7:0] v, input logic exp);
    logic [7:0] r;
    logic a;
    bb_byte(v, r, a);
    check("link ack", {15'h0000, a}, {15'h0000, exp});
  endtask : bb_ack

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic s_write;
    run_cmd(1'h0, 8'hFE, 8'h03);
    check("write count", 16'(wq.size()), 16'h0003);
    for (int i = 0; i < 3; i++) begin
      check("write word", wq[i], {8'(8'hFE + i), wdat[i]});
    end
  endtask : s_write

  task automatic s_read;
    run_cmd(1'h1, 8'hFF, 8'h02);
    check("read count", 16'(rdq.size()), 16'h0002);
    check("read byte0", {8'h00, rdq[0]}, {8'h00, wdat[1]});
    check("read byte1", {8'h00, rdq[1]}, {8'h00, wdat[2]});
    check("read writes", 16'(wq.size()), 16'h0000);
  endtask : s_read

  task automatic s_empty;
    run_cmd(1'h0, 8'h40, 8'h00);
    check("empty writes", 16'(wq.size()), 16'h0000);
  endtask : s_empty

  task automatic s_foreign;
    bb_start();
    bb_ack({DEV_ADDR ^ 7'h01, RW_WRITE}, NACK);
    bb_ack(8'h00, NACK);
    bb_stop();
  endtask : s_foreign

  task automatic s_last_ptr;
    logic [7:0] r;
    logic a;
    bb_start();
    bb_ack({DEV_ADDR, RW_WRITE}, ACK);
    bb_ack(8'hFF, ACK);
    bb_ack(8'h5A, ACK);
    bb_stop();
    bb_start();
    bb_ack({DEV_ADDR, RW_WRITE}, ACK);
    bb_ack(8'hFF, ACK);
    bb_stop();
    bb_start();
    bb_ack({DEV_ADDR, RW_READ}, ACK);
    bb_byte(8'hFF, r, a);
    check("last pointer", {8'h00, r}, 16'h005A);
    check("nack bit", {15'h0000, a}, 16'h0001);
    bb_stop();
    check("line free", {15'h0000, bus2.sda}, 16'h0001);
  endtask : s_last_ptr

  initial begin
    bus2.scl_o = 1'h0;
    bus2.sda_m_o = 1'h0;
    bus2.scl_oe = 1'h0;
    bus2.sda_m_oe = 1'h0;
    // Real rising edge, clears the link-clocked flops
    #1;
    srst_in = 1'h1;
    repeat (6) @(posedge ref_clk_in);
    #1;
    srst_in = 1'h0;
    s_write();
    s_read();
    s_empty();
    s_foreign();
    s_last_ptr();
    complete_run();
  end

endmodule : testbench

`default_nettype wire
